// file: design/ufe_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module ufe_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];   // storage
  logic [AW-1:0]    wp_q;             // write pointer
  logic [AW-1:0]    rp_q;             // read pointer
  logic [AW:0]      cnt_q;            // fill count
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;

  // storage has no reset; only pointers and fill count carry state
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_q[wp_q] <= i_in_data;
    end
  end

  // pointers and honest full/empty flags
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= AW'(wp_q + 1'b1);
      if (pop)  rp_q <= AW'(rp_q + 1'b1);
      cnt_q <= (AW+1)'(cnt_q + push - pop);
    end
  end

  assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rp_q];
endmodule

// file: design/ufe_pkg.sv
// shared constants for the serial port with framing error check
package ufe_pkg;
  // serial modes, two-bit select
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_8BIT = 2'h1;
  localparam logic [1:0] MODE_9FIX = 2'h2;
  localparam logic [1:0] MODE_9VAR = 2'h3;
  // clock and fixed-rate divisors
  localparam int CLK_MHZ        = 100;
  localparam int SYNC_DIV       = 12;
  localparam int FIX_DIV_SLOW   = 64;
  localparam int FIX_DIV_FAST   = 32;
  // reset values
  localparam logic [15:0] DIV_RST = 16'h0364;
  // receive fifo entry: 9 data bits plus frame error bit
  localparam int RX_W           = 10;
  localparam int FIFO_DEPTH     = 16;
  // shared receiver and transmitter states
  typedef enum logic [2:0] {
    UFE_RX_IDLE, UFE_RX_START, UFE_RX_DATA, UFE_RX_STOP, UFE_RX_SYNC
  } ufe_rx_st_t;
  typedef enum logic [1:0] {
    UFE_TX_IDLE, UFE_TX_SHIFT, UFE_TX_DONE
  } ufe_tx_st_t;
endpackage

// file: design/ufe_uart.sv
// serial port: sync mode and three async modes with framing error check
// Notes on behaviour
// (RL1) async modes 1, 2, 3 act as UART
// (RL2) mode 0 is synchronous shift mode
// (RL3) tx and rx run independently, separate rates
// (RL4) frame check only async, only when selected
// (RL5) receiver samples every frame's stop bit
// (RL6) bad stop bit sets frame error flag
// (RL7) low stop is bad; flag sticky until cleared
`timescale 1ns/1ps
module ufe_uart
  import ufe_pkg::*;
#(
  parameter int DIV_W = 16
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  // configuration
  input  wire logic [1:0]       i_mode,
  input  wire logic             i_framing_check_select,
  input  wire logic             i_rx_enable,
  input  wire logic             i_fast_rate,
  input  wire logic [DIV_W-1:0] i_tx_div,
  input  wire logic [DIV_W-1:0] i_rx_div,
  input  wire logic             i_frame_error_clear,
  // transmit request
  input  wire logic             i_tx_valid,
  input  wire logic [8:0]       i_tx_data,
  output logic                  o_tx_ready,
  // receive stream
  output logic                  o_rx_valid,
  output logic [8:0]            o_rx_data,
  output logic                  o_rx_frame_bad,
  input  wire logic             i_rx_ready,
  // status
  output logic                  o_frame_error_flag,
  output logic                  o_rx_overrun,
  // pins
  input  wire logic             i_rxd,
  output logic                  o_rxd_out,
  output logic                  o_rxd_oe,
  output logic                  o_txd
);
  // bit period in clocks for a given mode and programmable divisor
  // fixed rates ignore the divisor; a zero divisor would wrap the
  // counter to its top value, so it is read as one clock per bit
  function automatic logic [DIV_W-1:0] bit_period(
    input logic [1:0] mode, input logic fast, input logic [DIV_W-1:0] div);
    logic [DIV_W-1:0] r;
    r = div;
    case (mode)
      MODE_SYNC: r = DIV_W'(SYNC_DIV);
      MODE_9FIX: r = fast ? DIV_W'(FIX_DIV_FAST) : DIV_W'(FIX_DIV_SLOW);
      default:   r = (div == '0) ? DIV_W'(1) : div;
    endcase
    return r;
  endfunction

  // frame length in data bits: 8 in modes 0 and 1, 9 otherwise
  function automatic logic [3:0] data_bits(input logic [1:0] mode);
    return (mode == MODE_SYNC || mode == MODE_8BIT) ? 4'h8 : 4'h9;
  endfunction

  // two-flop synchroniser on the receive pin
  // both flops reset to the idle level so no false start follows reset
  logic rxd_m_q, rxd_s_q;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
    end else begin
      rxd_m_q <= i_rxd;
      rxd_s_q <= rxd_m_q;
    end
  end

  // mode decode and per-direction bit periods, shared by both halves
  wire              is_async = (i_mode != MODE_SYNC);            // (RL1)
  wire [DIV_W-1:0]  tx_per   = bit_period(i_mode, i_fast_rate, i_tx_div);
  wire [DIV_W-1:0]  rx_per   = bit_period(i_mode, i_fast_rate, i_rx_div);
  wire [3:0]        nbits    = data_bits(i_mode);

  // ---------------- transmitter, own rate counter -------------------
  ufe_tx_st_t       tx_st_q;
  logic [DIV_W-1:0] tx_cnt_q;      // clocks left in current bit
  logic [3:0]       tx_bit_q;      // bits left in frame
  logic [10:0]      tx_sh_q;       // shift register, lsb goes out
  logic             txd_q;         // serial out
  logic             tx_ready_q;    // registered ready
  logic             sclk_q;        // sync shift clock on txd
  wire              tx_tick  = (tx_cnt_q == DIV_W'(1));
  wire              tx_take  = tx_ready_q && i_tx_valid;
  wire [10:0]       tx_frame = (i_mode == MODE_8BIT) ?
                               {2'b11, i_tx_data[7:0], 1'b0} :
                               {1'b1, i_tx_data, 1'b0};

  // transmitter runs from its own divisor so rx/tx rates differ (RL3)
  // a request is taken only in idle and never queued, so the caller
  // must hold valid until it sees ready
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_st_q    <= UFE_TX_IDLE;
      tx_cnt_q   <= '0;
      tx_bit_q   <= '0;
      tx_sh_q    <= '1;
      txd_q      <= 1'b1;
      tx_ready_q <= 1'b0;
      sclk_q     <= 1'b1;
    end else begin
      case (tx_st_q)
        UFE_TX_IDLE: begin
          tx_ready_q <= 1'b1;
          txd_q      <= 1'b1;
          sclk_q     <= 1'b1;
          if (tx_take) begin
            tx_ready_q <= 1'b0;
            tx_cnt_q   <= tx_per;
            tx_st_q    <= UFE_TX_SHIFT;
            if (is_async) begin
              tx_sh_q  <= tx_frame;
              tx_bit_q <= nbits + 4'h2;  // start, data, stop
            end else begin
              // sync mode: 8 data bits, no start or stop (RL2)
              tx_sh_q  <= {3'b111, i_tx_data[7:0]};
              tx_bit_q <= 4'h8;
            end
          end
        end
        UFE_TX_SHIFT: begin
          // a bit ends when its counter reaches one, then it reloads
          txd_q  <= is_async ? tx_sh_q[0] : sclk_q;
          // sync: clock low first half, high second half of bit
          sclk_q <= (tx_cnt_q > (tx_per >> 1)) ? 1'b0 : 1'b1;
          if (tx_tick) begin
            tx_cnt_q <= tx_per;
            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
            tx_bit_q <= tx_bit_q - 4'h1;
            if (tx_bit_q == 4'h1) tx_st_q <= UFE_TX_DONE;
          end else begin
            tx_cnt_q <= tx_cnt_q - DIV_W'(1);
          end
        end
        UFE_TX_DONE: begin
          // one spare cycle keeps the stop bit whole before a new start
          txd_q   <= 1'b1;
          sclk_q  <= 1'b1;
          tx_st_q <= UFE_TX_IDLE;
        end
        default: tx_st_q <= UFE_TX_IDLE;
      endcase
    end
  end

  // sync mode drives data on rxd while shifting
  // the data copy follows the shift register every cycle; the enable
  // gates it, so its value while released does not matter
  logic rxd_oe_q, rxd_out_q;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rxd_oe_q  <= 1'b0;
      rxd_out_q <= 1'b1;
    end else begin
      rxd_oe_q  <= !is_async && (tx_st_q == UFE_TX_SHIFT);  // (RL2)
      rxd_out_q <= tx_sh_q[0];
    end
  end

  // ---------------- receiver, own rate counter ----------------------
  ufe_rx_st_t       rx_st_q;
  logic [DIV_W-1:0] rx_cnt_q;     // clocks to next sample point
  logic [3:0]       rx_bit_q;     // data bits left
  logic [8:0]       rx_sh_q;      // assembled data
  logic             rx_push_q;    // one-cycle push into fifo
  logic [RX_W-1:0]  rx_word_q;    // word pushed into fifo
  wire              rx_tick = (rx_cnt_q == DIV_W'(1));
  wire              fifo_in_ready;
  // stop sampled low is a bad stop bit (RL7)
  wire              stop_bad = !rxd_s_q;
  wire              check_on = is_async && i_framing_check_select; // (RL4)
  wire [8:0]        rx_next  = {rxd_s_q, rx_sh_q[8:1]};

  // receiver: start detect, mid-bit sampling, stop check
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_st_q   <= UFE_RX_IDLE;
      rx_cnt_q  <= '0;
      rx_bit_q  <= '0;
      rx_sh_q   <= '0;
      rx_push_q <= 1'b0;
      rx_word_q <= '0;
    end else begin
      rx_push_q <= 1'b0;
      case (rx_st_q)
        UFE_RX_IDLE: begin
          // after a low stop the line may still be low, so the hunt can
          // restart at once; the mid-start check drops that false start
          if (i_rx_enable && is_async && !rxd_s_q) begin
            rx_cnt_q <= DIV_W'(rx_per >> 1) | DIV_W'(1);  // mid start bit
            rx_st_q  <= UFE_RX_START;
          end
        end
        UFE_RX_START: begin
          // start is checked at its middle; later bits follow whole periods
          if (rx_tick) begin
            rx_cnt_q <= rx_per;
            rx_bit_q <= nbits;
            // false start: line back high at mid-bit
            rx_st_q  <= rxd_s_q ? UFE_RX_IDLE : UFE_RX_DATA;
          end else begin
            rx_cnt_q <= rx_cnt_q - DIV_W'(1);
          end
        end
        UFE_RX_DATA: begin
          // data arrive lsb first into the top of the shift register
          if (rx_tick) begin
            rx_cnt_q <= rx_per;
            rx_sh_q  <= rx_next;
            rx_bit_q <= rx_bit_q - 4'h1;
            if (rx_bit_q == 4'h1) rx_st_q <= UFE_RX_STOP;
          end else begin
            rx_cnt_q <= rx_cnt_q - DIV_W'(1);
          end
        end
        UFE_RX_STOP: begin
          if (rx_tick) begin
            // every frame's stop bit is examined here (RL5)
            // eight-bit frames sit one place high in the shift register
            rx_push_q <= 1'b1;
            rx_word_q <= {stop_bad, (nbits == 4'h8) ?
                          {1'b0, rx_sh_q[8:1]} : rx_sh_q};
            rx_st_q   <= UFE_RX_IDLE;
          end else begin
            rx_cnt_q <= rx_cnt_q - DIV_W'(1);
          end
        end
        default: rx_st_q <= UFE_RX_IDLE;
      endcase
    end
  end

  // frame error flag: set wins over software clear; a later good frame
  // leaves it alone, so software always sees the fault
  logic fe_q, ovr_q;
  wire  fe_set = rx_push_q && rx_word_q[RX_W-1] && check_on;      // (RL6)
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fe_q  <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      if (fe_set) fe_q <= 1'b1;                                   // (RL6)
      else if (i_frame_error_clear) fe_q <= 1'b0;                 // (RL7)
      // a word lost to a full fifo is reported, sticky, same clear
      // one clear serves both flags so software needs a single action
      if (rx_push_q && !fifo_in_ready) ovr_q <= 1'b1;
      else if (i_frame_error_clear) ovr_q <= 1'b0;
    end
  end

  // receive fifo decouples the byte stream from the reader
  // seen from the port the capacity is the depth plus the output stage,
  // so one word more than the depth fits before an overrun
  logic             f_valid;
  logic [RX_W-1:0]  f_data;
  logic             out_v_q;
  logic [RX_W-1:0]  out_d_q;
  wire              take_out = f_valid && (!out_v_q || i_rx_ready);
  ufe_fifo #(.WIDTH(RX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (rx_push_q),
    .i_in_data   (rx_word_q),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (take_out)
  );

  // output register stage so every output comes from a flop
  // a word leaves on ready and the next one moves up in the same cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_v_q <= 1'b0;
      out_d_q <= '0;
    end else begin
      if (take_out) begin
        out_v_q <= 1'b1;
        out_d_q <= f_data;
      end else if (i_rx_ready) begin
        out_v_q <= 1'b0;
      end
    end
  end

  // every port below is a plain copy of a register
  assign o_tx_ready         = tx_ready_q;
  assign o_txd              = txd_q;
  assign o_rxd_oe           = rxd_oe_q;
  assign o_rxd_out          = rxd_out_q;
  assign o_rx_valid         = out_v_q;
  assign o_rx_data          = out_d_q[8:0];
  assign o_rx_frame_bad     = out_d_q[RX_W-1];
  assign o_frame_error_flag = fe_q;
  assign o_rx_overrun       = ovr_q;
endmodule

// file: tb/ufe_remote.sv
// remote serial station: drives the receive pin, reads the transmit pin
`timescale 1ns/1ps
module ufe_remote (
  // clock
  input  wire logic i_clock,
  // serial lines
  input  wire logic i_txd,
  output logic      o_rxd
);
  initial o_rxd = 1'b1; // pulled-up line idles high
  // one frame lsb first; the caller picks the stop level
  task automatic send(input logic [8:0] d, input int n, input int per,
                      input logic stop);
    @(posedge i_clock);
    o_rxd <= 1'b0;
    repeat (per) @(posedge i_clock);
    for (int b = 0; b < n; b++) begin
      o_rxd <= d[b];
      repeat (per) @(posedge i_clock);
    end
    o_rxd <= stop; // low here breaks the frame on purpose
    repeat (per) @(posedge i_clock);
    o_rxd <= 1'b1; // released line returns to idle
    repeat (per) @(posedge i_clock);
  endtask
  // catch one frame, sampled mid-bit; ok low on timeout or bad stop
  task automatic take(input int n, input int per, output logic [8:0] d,
                      output logic ok);
    int w = 0;
    d = '0;
    while (i_txd !== 1'b0 && w < 4000) begin
      @(posedge i_clock);
      w++;
    end
    ok = (w < 4000);
    repeat (per / 2) @(posedge i_clock);
    for (int b = 0; b < n; b++) begin
      repeat (per) @(posedge i_clock);
      d[b] = i_txd;
    end
    repeat (per) @(posedge i_clock);
    ok = ok && (i_txd === 1'b1);
  endtask
endmodule

// file: tb/ufe_uart_checker.sv
// port-level checker for the serial port with framing error check
`timescale 1ns/1ps
module ufe_uart_checker
  import ufe_pkg::*;
(
  // clock, reset and controls
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic [1:0] i_mode,
  input wire logic       i_framing_check_select,
  input wire logic       i_frame_error_clear,
  input wire logic       i_tx_valid,
  input wire logic       i_rx_ready,
  // observed outputs
  input wire logic       o_tx_ready,
  input wire logic       o_rx_valid,
  input wire logic [8:0] o_rx_data,
  input wire logic       o_rx_frame_bad,
  input wire logic       o_frame_error_flag,
  input wire logic       o_rxd_oe,
  input wire logic       o_txd
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // async modes share the framing logic
  wire logic async_m;
  assign async_m = (i_mode != MODE_SYNC);
  tx_take_a: assert property (o_tx_ready && i_tx_valid |=> !o_tx_ready)
    else $error("ready stayed high after a take");
  tx_start_a: assert property (o_tx_ready && i_tx_valid && async_m
    |-> ##[1:2] !o_txd) else $error("no start bit");
  tx_idle_a: assert property (o_tx_ready && async_m && $past(async_m)
    |-> o_txd) else $error("idle line not high");
  rx_hold_a: assert property (o_rx_valid && !i_rx_ready
    |=> o_rx_valid && $stable(o_rx_data)) else $error("word lost");
  flag_keep_a: assert property (o_frame_error_flag && !i_frame_error_clear
    |=> o_frame_error_flag) else $error("flag dropped");
  flag_cause_a: assert property ($rose(o_frame_error_flag)
    |-> $past(i_framing_check_select) && $past(async_m))
    else $error("flag set while check off");
  bad_flag_a: assert property (o_rx_valid && o_rx_frame_bad && async_m
    && i_framing_check_select && !i_frame_error_clear |-> o_frame_error_flag)
    else $error("bad frame without flag");
  oe_async_a: assert property (async_m && $past(async_m) |-> !o_rxd_oe)
    else $error("pin driven in async mode");
endmodule
bind ufe_uart ufe_uart_checker i_ufe_uart_checker (.*);

// file: tb/ufe_uart_tb.sv
// self-checking testbench for the serial port with framing error check
`timescale 1ns/1ps
module ufe_uart_tb;
  import ufe_pkg::*;
  // design signals, named as its ports
  logic       i_clock, i_rst_n, i_framing_check_select, i_rx_enable;
  logic       i_fast_rate, i_frame_error_clear, i_tx_valid, i_rx_ready;
  logic [1:0] i_mode;
  logic [15:0] i_tx_div, i_rx_div;
  logic [8:0] i_tx_data, o_rx_data;
  logic       o_tx_ready, o_rx_valid, o_rx_frame_bad, o_frame_error_flag;
  logic       o_rx_overrun, i_rxd, o_rxd_out, o_rxd_oe, o_txd;
  int         mismatches, comparisons;
  localparam int TXP = 16; // rates differ on purpose
  localparam int RXP = 20;
  ufe_uart i_ufe_uart (.*);
  ufe_remote i_ufe_remote (.i_clock(i_clock), .i_txd(o_txd), .o_rxd(i_rxd));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // sample after the edge's updates have landed
  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_word(input logic [8:0] g, input logic [8:0] e,
                          input string m);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: %s %h", $time, m, g);
    end
  endtask
  task automatic cfg(input logic [1:0] m, input logic chk);
    i_mode <= m;
    i_framing_check_select <= chk;
    tick();
  endtask
  task automatic clear;
    i_frame_error_clear <= 1'b1;
    tick();
    i_frame_error_clear <= 1'b0;
    tick();
  endtask
  // bounded wait for a word, compare, then accept it
  task automatic get_rx(input logic [8:0] e, input logic [8:0] m,
                        input logic bad);
    int w = 0;
    while (o_rx_valid !== 1'b1 && w < 4000) begin
      tick();
      w++;
    end
    chk_bit(o_rx_valid, 1'b1, "no word");
    chk_word(o_rx_data & m, e & m, "rx data");
    chk_bit(o_rx_frame_bad, bad, "stop status");
    i_rx_ready <= 1'b1;
    tick();
    i_rx_ready <= 1'b0;
    tick();
  endtask
  task automatic put_tx(input logic [8:0] d);
    int w = 0;
    while (o_tx_ready !== 1'b1 && w < 4000) begin
      tick();
      w++;
    end
    i_tx_valid <= 1'b1;
    i_tx_data <= d;
    tick();
    i_tx_valid <= 1'b0;
  endtask
  // both directions at once, each at its own rate
  task automatic t_duplex;
    logic [8:0] d;
    logic       ok;
    cfg(MODE_8BIT, 1'b1);
    fork
      i_ufe_remote.send(9'h0A5, 8, RXP, 1'b1);
      put_tx(9'h03C);
      i_ufe_remote.take(8, TXP, d, ok);
    join
    chk_word(d, 9'h03C, "tx data");
    chk_bit(ok, 1'b1, "tx stop");
    get_rx(9'h0A5, 9'h0FF, 1'b0);
    chk_bit(o_frame_error_flag, 1'b0, "flag on good frame");
    $display("duplex done");
  endtask
  // low stop sets the flag; a good frame leaves it set
  task automatic t_bad;
    cfg(MODE_8BIT, 1'b1);
    i_ufe_remote.send(9'h05A, 8, RXP, 1'b0);
    get_rx(9'h05A, 9'h0FF, 1'b1);
    chk_bit(o_frame_error_flag, 1'b1, "flag after bad stop");
    i_ufe_remote.send(9'h033, 8, RXP, 1'b1);
    get_rx(9'h033, 9'h0FF, 1'b0);
    chk_bit(o_frame_error_flag, 1'b1, "flag after good");
    clear();
    chk_bit(o_frame_error_flag, 1'b0, "flag after clear");
    $display("bad stop done");
  endtask
  // nine-bit modes check framing too; check off ignores it
  task automatic t_modes;
    logic [8:0] d;
    logic       ok;
    logic [1:0] m;
    for (int k = 0; k < 2; k++) begin
      m = k ? MODE_9VAR : MODE_9FIX;
      cfg(m, 1'b1);
      fork
        i_ufe_remote.send(9'h1A5, 9, k ? RXP : FIX_DIV_FAST, 1'b0);
        put_tx(9'h14B);
        i_ufe_remote.take(9, k ? TXP : FIX_DIV_FAST, d, ok);
      join
      chk_word(d, 9'h14B, "nine-bit tx data");
      chk_bit(ok, 1'b1, "nine-bit tx stop");
      get_rx(9'h1A5, 9'h1FF, 1'b1);
      chk_bit(o_frame_error_flag, 1'b1, "nine-bit flag");
      clear();
    end
    cfg(MODE_8BIT, 1'b0);
    i_ufe_remote.send(9'h011, 8, RXP, 1'b0);
    get_rx(9'h011, 9'h0FF, 1'b1);
    chk_bit(o_frame_error_flag, 1'b0, "flag with check off");
    $display("modes done");
  endtask
  // fill one past fifo plus output stage while stalled, then drain it
  task automatic t_fifo;
    for (int k = 0; k <= FIFO_DEPTH + 1; k++) begin
      i_ufe_remote.send(9'(k), 8, RXP, 1'b1);
    end
    chk_bit(o_rx_overrun, 1'b1, "overrun");
    for (int k = 0; k <= FIFO_DEPTH; k++) begin
      get_rx(9'(k), 9'h0FF, 1'b0);
    end
    chk_bit(o_rx_valid, 1'b0, "buffer empty");
    clear();
    chk_bit(o_rx_overrun, 1'b0, "overrun after clear");
    $display("buffer done");
  endtask
  // shift mode drives the data pin, one rising clock on txd per bit
  task automatic t_sync;
    logic       seen = 1'b0;
    logic       prev = 1'b1;
    logic [8:0] got  = '0;
    int         n    = 0;
    cfg(MODE_SYNC, 1'b0);
    put_tx(9'h081);
    for (int k = 0; k < 200; k++) begin
      tick();
      seen = seen | (o_rxd_oe === 1'b1);
      if (prev === 1'b0 && o_txd === 1'b1 && o_rxd_oe === 1'b1) begin
        got = {o_rxd_out, got[8:1]};
        n++;
      end
      prev = o_txd;
    end
    chk_bit(seen, 1'b1, "shift mode pin drive");
    chk_word({1'b0, got[8:1]}, 9'h081, "shift mode data");
    chk_bit(n == 8, 1'b1, "shift clock count");
    $display("sync done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog sized well past the expected run
  initial begin
    repeat (40000) @(posedge i_clock);
    mismatches++;
    close_out();
  end
  initial begin
    i_rst_n = 1'b0;
    i_mode = MODE_8BIT;
    i_framing_check_select = 1'b0;
    i_rx_enable = 1'b1;
    i_fast_rate = 1'b1;
    i_tx_div = 16'(TXP);
    i_rx_div = 16'(RXP);
    i_frame_error_clear = 1'b0;
    i_tx_valid = 1'b0;
    i_tx_data = '0;
    i_rx_ready = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    tick();
    tick();
    t_duplex();
    t_bad();
    t_modes();
    t_fifo();
    t_sync();
    close_out();
  end
endmodule
